// ### dv/coproc_access_and_secure_config_monitor.sv
// checker for the coprocessor access and secure config block.
// assumes it is bound to the top module and sees only its ports.
`timescale 1ns/10ps
module coproc_access_and_secure_config_monitor
(
	input wire logic clock,
	input wire logic nrst,
	input wire logic ce,
	input wire logic sys_req,
	input wire logic sys_write,
	input wire logic [2:0] sys_opc1,
	input wire logic [3:0] sys_crn,
	input wire logic [3:0] sys_crm,
	input wire logic [2:0] sys_opc2,
	input wire logic [31:0] sys_wdata,
	input wire logic mode_user,
	input wire logic mode_monitor,
	input wire logic instr_valid,
	input wire logic [3:0] instr_coproc,
	input wire logic instr_vector,
	input wire logic sys_done_q,
	input wire logic sys_hit_q,
	input wire logic sys_undef_q,
	input wire logic [31:0] sys_rdata_q,
	input wire logic instr_done_q,
	input wire logic instr_undef_q,
	input wire logic nonsecure_q,
	input wire logic fast_irq_mask_bit_writable_q,
	input wire logic abort_mask_bit_writable_q
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);

	// access control encoding: opc1 0, c1, c0, opc2 2
	wire acr_enc = sys_opc1 == 3'h0 && sys_crn == 4'h1 && sys_crm == 4'h0 && sys_opc2 == 3'h2;
	// secure config encoding: opc1 0, c1, c1, opc2 0
	wire scr_enc = sys_opc1 == 3'h0 && sys_crn == 4'h1 && sys_crm == 4'h1 && sys_opc2 == 3'h0;
	logic vdis_q;

	// shadow of the vector disable bit, since the checker cannot see storage
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			vdis_q <= 1'b0;
		else if (ce && sys_req && sys_write && acr_enc && !mode_user)
			vdis_q <= sys_wdata[31];
	end

	req_answered_a: assert property (ce && sys_req |=> sys_done_q)
		else $error("move request not answered");
	idle_quiet_a: assert property (ce && !sys_req |=> !sys_done_q && !sys_hit_q && !sys_undef_q)
		else $error("move answer without request");
	user_acr_refused_a: assert property (ce && sys_req && acr_enc && mode_user |=> sys_undef_q && sys_rdata_q == 32'h0)
		else $error("user access control move not refused");
	kernel_acr_hit_a: assert property (ce && sys_req && acr_enc && !mode_user |=> sys_hit_q && !sys_undef_q)
		else $error("kernel access control move refused");
	reserved_zero_a: assert property (ce && sys_req && acr_enc |=> sys_rdata_q[29:24] == 6'h00 && sys_rdata_q[19:0] == 20'h0)
		else $error("reserved read bits not zero");
	user_scr_refused_a: assert property (ce && sys_req && scr_enc && mode_user |=> sys_undef_q)
		else $error("user secure config move not refused");
	other_coproc_a: assert property (ce && instr_valid && instr_coproc[3:1] != 3'h5 |=> instr_done_q && instr_undef_q)
		else $error("absent coprocessor not undefined");
	vector_off_a: assert property (ce && instr_valid && instr_vector && vdis_q |=> instr_undef_q)
		else $error("vector instruction allowed while disabled");
	monitor_secure_a: assert property (ce && mode_monitor |=> !nonsecure_q)
		else $error("monitor mode seen nonsecure");
	secure_masks_a: assert property (!nonsecure_q |-> fast_irq_mask_bit_writable_q && abort_mask_bit_writable_q)
		else $error("mask bits locked in secure state");

	// main scenarios reached
	cover property (ce && sys_req && sys_write && acr_enc && !mode_user);
	cover property (instr_done_q && !instr_undef_q);
	cover property (nonsecure_q && !fast_irq_mask_bit_writable_q);
endmodule

bind coproc_access_and_secure_config coproc_access_and_secure_config_monitor mon (.clock(clock), .nrst(nrst),
	.ce(ce), .sys_req(sys_req), .sys_write(sys_write), .sys_opc1(sys_opc1), .sys_crn(sys_crn),
	.sys_crm(sys_crm), .sys_opc2(sys_opc2), .sys_wdata(sys_wdata), .mode_user(mode_user),
	.mode_monitor(mode_monitor), .instr_valid(instr_valid), .instr_coproc(instr_coproc),
	.instr_vector(instr_vector), .sys_done_q(sys_done_q), .sys_hit_q(sys_hit_q), .sys_undef_q(sys_undef_q),
	.sys_rdata_q(sys_rdata_q), .instr_done_q(instr_done_q), .instr_undef_q(instr_undef_q),
	.nonsecure_q(nonsecure_q), .fast_irq_mask_bit_writable_q(fast_irq_mask_bit_writable_q),
	.abort_mask_bit_writable_q(abort_mask_bit_writable_q));

// ### dv/coproc_access_and_secure_config_tb_top.sv
// self-checking bench: random moves and instruction checks against a model.
// assumes the default build, with fpu and vector extension both present.
`timescale 1ns/10ps
module coproc_access_and_secure_config_tb_top;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic ce, sys_req, sys_write, mode_user, mode_monitor, instr_valid, instr_vector, instr_upper_regs;
	logic [2:0] sys_opc1, sys_opc2;
	logic [3:0] sys_crn, sys_crm, instr_coproc;
	logic [31:0] sys_wdata, sys_rdata_q, e_rd, seed;
	logic sys_done_q, sys_hit_q, sys_undef_q, instr_done_q, instr_undef_q, nonsecure_q;
	logic irq_to_monitor_q, fiq_to_monitor_q, abort_to_monitor_q, fw_q, aw_q;
	logic vd, ud;
	logic [1:0] r10, r11, e_ins, e_wr;
	logic [2:0] e_sys;
	logic [3:0] e_sec;
	logic [5:0] sc;
	int num_errors = 0;
	int samples_checked = 0;

	coproc_access_and_secure_config dut (.clock(clock), .nrst(nrst), .ce(ce), .sys_req(sys_req),
		.sys_write(sys_write), .sys_opc1(sys_opc1), .sys_crn(sys_crn), .sys_crm(sys_crm), .sys_opc2(sys_opc2),
		.sys_wdata(sys_wdata), .mode_user(mode_user), .mode_monitor(mode_monitor), .instr_valid(instr_valid),
		.instr_coproc(instr_coproc), .instr_vector(instr_vector), .instr_upper_regs(instr_upper_regs),
		.sys_done_q(sys_done_q), .sys_hit_q(sys_hit_q), .sys_undef_q(sys_undef_q), .sys_rdata_q(sys_rdata_q),
		.instr_done_q(instr_done_q), .instr_undef_q(instr_undef_q), .nonsecure_q(nonsecure_q),
		.irq_to_monitor_q(irq_to_monitor_q), .fiq_to_monitor_q(fiq_to_monitor_q),
		.abort_to_monitor_q(abort_to_monitor_q), .fast_irq_mask_bit_writable_q(fw_q),
		.abort_mask_bit_writable_q(aw_q));

	// free-running 100 MHz clock
	always #5 clock = ~clock;

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict();
		if (num_errors == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// random stimulus, biased towards the two real encodings so writes land
	task automatic drive();
		logic [31:0] r;
		logic [31:0] w;
		seed = xs(seed);
		r = seed;
		w = xs(r);
		// software only rarely sets the deprecated upper-regs disable
		w[30] = w[30] && w[29] && w[28];
		// software keeps both rights fields equal, mismatch is unpredictable
		w[23:22] = w[21:20];
		ce <= r[2:0] != 3'h0;
		sys_req <= r[3];
		sys_write <= r[4];
		{sys_opc1, sys_crn, sys_crm, sys_opc2} <= r[6:5] == 2'h3 ? r[20:7] : (r[5] ? 14'h0088 : 14'h0082);
		sys_wdata <= w;
		mode_user <= r[22:21] == 2'h0;
		mode_monitor <= r[22:21] == 2'h1;
		instr_valid <= r[23];
		instr_coproc <= r[24] ? r[28:25] : {3'h5, r[25]};
		instr_vector <= r[29];
		instr_upper_regs <= r[30];
	endtask

	// model: works out the answer to the coming edge, then updates storage;
	// a disabled edge leaves both outputs and storage as they were
	task automatic predict();
		logic a, s, sec;
		logic [1:0] rt;
		if (!ce)
			return;
		a = sys_opc1 == 3'h0 && sys_crn == 4'h1 && sys_crm == 4'h0 && sys_opc2 == 3'h2;
		s = sys_opc1 == 3'h0 && sys_crn == 4'h1 && sys_crm == 4'h1 && sys_opc2 == 3'h0;
		sec = !sc[0] || mode_monitor;
		e_sec = {sc[0] && !mode_monitor, sc[3:1]};
		e_wr = {sec || sc[4], sec || sc[5]};
		rt = instr_coproc == 4'ha ? r10 : (instr_coproc == 4'hb ? r11 : 2'h0);
		e_ins = {instr_valid, instr_valid && (rt == 2'h0 || rt == 2'h2 || (rt == 2'h1 && mode_user)
			|| (instr_vector && vd) || (instr_upper_regs && ud))};
		e_sys = {sys_req, sys_req && (a || s), sys_req && ((a && mode_user) || (s && (mode_user || !sec)))};
		e_rd = 32'h0;
		if (e_sys == 3'h6 && !sys_write)
			e_rd = a ? {vd, ud, 6'h00, r11, r10, 20'h0} : {26'h0, sc};
		if (e_sys == 3'h6 && sys_write && a)
			{vd, ud, r11, r10} = {sys_wdata[31:30], sys_wdata[23:20]};
		if (e_sys == 3'h6 && sys_write && s)
			sc = sys_wdata[5:0];
	endtask

	task automatic cmp();
		chk(32'({sys_done_q, sys_hit_q, sys_undef_q}), 32'(e_sys));
		chk(sys_rdata_q, e_rd);
		chk(32'({instr_done_q, instr_undef_q}), 32'(e_ins));
		chk(32'({nonsecure_q, abort_to_monitor_q, fiq_to_monitor_q, irq_to_monitor_q}), 32'(e_sec));
		chk(32'({fw_q, aw_q}), 32'(e_wr));
	endtask

	// hang guard, well beyond the 3000 steps of the run
	initial
	begin
		#200000;
		num_errors++;
		give_verdict();
	end

	// reset, check reset values, random traffic compared every cycle;
	// done twice so that a reset in mid-run with live traffic is covered
	initial
	begin
		{ce, sys_req, sys_write, mode_user, mode_monitor, instr_valid, instr_vector, instr_upper_regs} = 8'h00;
		{sys_opc1, sys_opc2, sys_crn, sys_crm, instr_coproc, sys_wdata} = 50'h0;
		seed = 32'h0000d272;
		repeat (2)
		begin
			@(posedge clock);
			nrst <= 1'b0;
			{vd, ud, r10, r11, sc, e_sys, e_rd, e_ins, e_sec} = 53'h0;
			e_wr = 2'h3;
			repeat (3) @(posedge clock);
			nrst <= 1'b1;
			#1;
			cmp();
			repeat (1500)
			begin
				predict();
				@(posedge clock);
				drive();
				#1;
				cmp();
			end
		end
		give_verdict();
	end
endmodule

// ### verilog/coproc_access_and_secure_config.sv
// holds the coprocessor access control and secure configuration logic of the
// core: the register moves, the per-instruction undefined check and the
// security routing outputs.
// assumes every input comes from core logic on the same clock, and that the
// mode inputs describe the mode of the instruction being presented.
`timescale 1ns/10ps
`include "coproc_defs.svh"
module coproc_access_and_secure_config
#(
	parameter bit FPU_PRESENT = 1'b1,
	parameter bit VECTOR_PRESENT = 1'b1
)
(
	input wire logic clock,
	input wire logic nrst,
	input wire logic ce,
	input wire logic sys_req,
	input wire logic sys_write,
	input wire logic [2:0] sys_opc1,
	input wire logic [3:0] sys_crn,
	input wire logic [3:0] sys_crm,
	input wire logic [2:0] sys_opc2,
	input wire logic [31:0] sys_wdata,
	input wire logic mode_user,
	input wire logic mode_monitor,
	input wire logic instr_valid,
	input wire logic [3:0] instr_coproc,
	input wire logic instr_vector,
	input wire logic instr_upper_regs,
	output logic sys_done_q,
	output logic sys_hit_q,
	output logic sys_undef_q,
	output logic [31:0] sys_rdata_q,
	output logic instr_done_q,
	output logic instr_undef_q,
	output logic nonsecure_q,
	output logic irq_to_monitor_q,
	output logic fiq_to_monitor_q,
	output logic abort_to_monitor_q,
	output logic fast_irq_mask_bit_writable_q,
	output logic abort_mask_bit_writable_q
);

	// a vector extension cannot exist without the fpu it extends
	generate
		if (VECTOR_PRESENT && !FPU_PRESENT)
		begin : g_bad_config
			$error("vector extension requires the floating-point unit");
		end
	endgenerate

	typedef struct packed {
		logic [1:0] ten_rights;
		logic [1:0] eleven_rights;
		logic vec_dis;
		logic upper_dis;
		logic sys_done;
		logic sys_hit;
		logic sys_undef;
		logic [31:0] sys_rdata;
		logic instr_done;
		logic instr_undef;
		logic nonsecure;
		logic irq_mon;
		logic fiq_mon;
		logic abort_mon;
		logic fiq_mask_wr;
		logic abort_mask_wr;
	} state_t;

	state_t s_q;
	state_t s_d;

	logic [`SECURE_CONFIG_WIDTH-1:0] scr_value;
	logic scr_write;
	logic [`SECURE_CONFIG_WIDTH-1:0] scr_wdata;
	logic ten_allow;
	logic eleven_allow;
	logic secure_now;
	logic eff_vec_dis;
	logic eff_upper_dis;
	coproc_pkg::sys_target_t target;

	// select the register addressed by a system coprocessor move
	function automatic coproc_pkg::sys_target_t decode_target(
		input logic [2:0] opc1,
		input logic [3:0] crn,
		input logic [3:0] crm,
		input logic [2:0] opc2
	);
		decode_target = coproc_pkg::TARGET_NONE;
		if (opc1 == `SYS_OPC1_ZERO && crn == `SYS_CRN_C1)
		begin
			if (crm == `ACCESS_CTRL_CRM && opc2 == `ACCESS_CTRL_OPC2)
			begin
				decode_target = coproc_pkg::TARGET_ACCESS_CTRL;
			end
			else if (crm == `SECURE_CONFIG_CRM && opc2 == `SECURE_CONFIG_OPC2)
			begin
				decode_target = coproc_pkg::TARGET_SECURE_CONFIG;
			end
		end
	endfunction

	// read image of coproc_access_ctrl; every other bit reads zero
	function automatic logic [31:0] access_ctrl_image(
		input logic [1:0] ten,
		input logic [1:0] eleven,
		input logic vdis,
		input logic udis
	);
		access_ctrl_image = 32'h0000_0000;
		if (FPU_PRESENT)
		begin
			access_ctrl_image[`VECTOR_EXT_DISABLE_BIT] = vdis;
			access_ctrl_image[`UPPER_FP_REGS_DISABLE_BIT] = udis;
			access_ctrl_image[`ELEVEN_RIGHTS_HI:`ELEVEN_RIGHTS_LO] = eleven;
			access_ctrl_image[`TEN_RIGHTS_HI:`TEN_RIGHTS_LO] = ten;
		end
	endfunction

	// effective disables: without the vector extension both stick at one;
	// without an fpu they read zero, standing in for the unknown value
	assign eff_vec_dis = VECTOR_PRESENT ? s_q.vec_dis : 1'b1;
	assign eff_upper_dis = VECTOR_PRESENT ? s_q.upper_dis : 1'b1;

	// monitor mode counts as secure whatever the flag says
	assign secure_now = !scr_value[`NONSECURE_FLAG_BIT] || mode_monitor;

	assign target = decode_target(sys_opc1, sys_crn, sys_crm, sys_opc2);

	// rights of the two floating-point coprocessors
	rights_check u_ten_check
	(
		.rights(s_q.ten_rights),
		.user_mode(mode_user),
		.allow(ten_allow)
	);

	rights_check u_eleven_check
	(
		.rights(s_q.eleven_rights),
		.user_mode(mode_user),
		.allow(eleven_allow)
	);

	// secure configuration storage
	secure_config_bank u_secure_config
	(
		.clock(clock),
		.nrst(nrst),
		.ce(ce),
		.write_en(scr_write),
		.write_data(scr_wdata),
		.value(scr_value)
	);

	// register moves, instruction checks and security outputs
	always_comb
	begin
		s_d = s_q;
		s_d.sys_done = 1'b0;
		s_d.sys_hit = 1'b0;
		s_d.sys_undef = 1'b0;
		s_d.sys_rdata = 32'h0000_0000;
		s_d.instr_done = 1'b0;
		s_d.instr_undef = 1'b0;
		scr_write = 1'b0;
		scr_wdata = sys_wdata[`SECURE_CONFIG_WIDTH-1:0];

		// one answer per move, one cycle after the request
		if (sys_req)
		begin
			s_d.sys_done = 1'b1;
			unique case (target)
				coproc_pkg::TARGET_ACCESS_CTRL:
				begin
					s_d.sys_hit = 1'b1;
					// single copy, no banking by security state
					if (mode_user)
					begin
						s_d.sys_undef = 1'b1;
					end
					else if (sys_write)
					begin
						// no fpu: whole register write-ignored
						if (FPU_PRESENT)
						begin
							s_d.eleven_rights = sys_wdata[`ELEVEN_RIGHTS_HI:`ELEVEN_RIGHTS_LO];
							s_d.ten_rights = sys_wdata[`TEN_RIGHTS_HI:`TEN_RIGHTS_LO];
						end
						// disables only store when the vector extension exists
						if (FPU_PRESENT && VECTOR_PRESENT)
						begin
							s_d.vec_dis = sys_wdata[`VECTOR_EXT_DISABLE_BIT];
							s_d.upper_dis = sys_wdata[`UPPER_FP_REGS_DISABLE_BIT];
						end
					end
					else
					begin
						s_d.sys_rdata = access_ctrl_image(s_q.ten_rights, s_q.eleven_rights,
							eff_vec_dis, eff_upper_dis);
					end
				end
				coproc_pkg::TARGET_SECURE_CONFIG:
				begin
					s_d.sys_hit = 1'b1;
					// restricted: secure kernel-privilege modes only
					if (mode_user || !secure_now)
					begin
						s_d.sys_undef = 1'b1;
					end
					else if (sys_write)
					begin
						scr_write = 1'b1;
					end
					else
					begin
						s_d.sys_rdata[`SECURE_CONFIG_WIDTH-1:0] = scr_value;
					end
				end
				coproc_pkg::TARGET_NONE:
				begin
					// other system registers live elsewhere; answered with no hit
					s_d.sys_hit = 1'b0;
				end
			endcase
		end

		// check uses the registered state, so a write taken at an edge
		// governs every instruction taken from the next edge on
		if (instr_valid)
		begin
			s_d.instr_done = 1'b1;
			if (!FPU_PRESENT)
			begin
				s_d.instr_undef = 1'b1;
			end
			else if (instr_coproc == `COPROC_TEN)
			begin
				s_d.instr_undef = !ten_allow;
			end
			else if (instr_coproc == `COPROC_ELEVEN)
			begin
				s_d.instr_undef = !eleven_allow;
			end
			else
			begin
				// coprocessors without rights here are not implemented
				s_d.instr_undef = 1'b1;
			end
			if (instr_vector && eff_vec_dis)
			begin
				s_d.instr_undef = 1'b1;
			end
			if (instr_upper_regs && eff_upper_dis)
			begin
				s_d.instr_undef = 1'b1;
			end
		end

		// routing and mask permissions follow the stored config one cycle later
		s_d.nonsecure = scr_value[`NONSECURE_FLAG_BIT] && !mode_monitor;
		s_d.irq_mon = scr_value[`IRQ_TO_MONITOR_BIT];
		s_d.fiq_mon = scr_value[`FIQ_TO_MONITOR_BIT];
		s_d.abort_mon = scr_value[`ABORT_TO_MONITOR_BIT];
		s_d.fiq_mask_wr = secure_now || scr_value[`FIQ_MASK_WRITABLE_BIT];
		s_d.abort_mask_wr = secure_now || scr_value[`ABORT_MASK_WRITABLE_BIT];
	end

	// state register; ce low freezes everything
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			s_q.ten_rights <= `RIGHTS_RESET;
			s_q.eleven_rights <= `RIGHTS_RESET;
			s_q.vec_dis <= `DISABLE_RESET;
			s_q.upper_dis <= `DISABLE_RESET;
			s_q.sys_done <= 1'b0;
			s_q.sys_hit <= 1'b0;
			s_q.sys_undef <= 1'b0;
			s_q.sys_rdata <= 32'h0000_0000;
			s_q.instr_done <= 1'b0;
			s_q.instr_undef <= 1'b0;
			s_q.nonsecure <= 1'b0;
			s_q.irq_mon <= 1'b0;
			s_q.fiq_mon <= 1'b0;
			s_q.abort_mon <= 1'b0;
			s_q.fiq_mask_wr <= 1'b1; // secure after reset, so writable
			s_q.abort_mask_wr <= 1'b1;
		end
		else if (ce)
		begin
			s_q <= s_d;
		end
	end

	// every output straight from the state register
	assign sys_done_q = s_q.sys_done;
	assign sys_hit_q = s_q.sys_hit;
	assign sys_undef_q = s_q.sys_undef;
	assign sys_rdata_q = s_q.sys_rdata;
	assign instr_done_q = s_q.instr_done;
	assign instr_undef_q = s_q.instr_undef;
	assign nonsecure_q = s_q.nonsecure;
	assign irq_to_monitor_q = s_q.irq_mon;
	assign fiq_to_monitor_q = s_q.fiq_mon;
	assign abort_to_monitor_q = s_q.abort_mon;
	assign fast_irq_mask_bit_writable_q = s_q.fiq_mask_wr;
	assign abort_mask_bit_writable_q = s_q.abort_mask_wr;
endmodule

// ### verilog/coproc_defs.svh
// holds the encodings, field positions and reset values of the coprocessor
// access control and secure configuration registers.
// assumes inclusion by bare name from the design files of this block.
`ifndef COPROC_DEFS_SVH
`define COPROC_DEFS_SVH

// system coprocessor move encodings shared by both registers
`define SYS_CRN_C1 4'h1
`define SYS_OPC1_ZERO 3'h0

// coproc_access_ctrl: opc1 0, c1, c0, opc2 2
`define ACCESS_CTRL_CRM 4'h0
`define ACCESS_CTRL_OPC2 3'h2

// secure_config: opc1 0, c1, c1, opc2 0
`define SECURE_CONFIG_CRM 4'h1
`define SECURE_CONFIG_OPC2 3'h0

// coproc_access_ctrl field positions
`define VECTOR_EXT_DISABLE_BIT 31
`define UPPER_FP_REGS_DISABLE_BIT 30
`define ELEVEN_RIGHTS_HI 23
`define ELEVEN_RIGHTS_LO 22
`define TEN_RIGHTS_HI 21
`define TEN_RIGHTS_LO 20
`define RIGHTS_RESET 2'h0
`define DISABLE_RESET 1'h0

// coprocessor numbers that the rights fields govern
`define COPROC_TEN 4'ha
`define COPROC_ELEVEN 4'hb

// secure_config field positions, width and reset value
`define SECURE_CONFIG_WIDTH 6
`define NONSECURE_FLAG_BIT 0
`define IRQ_TO_MONITOR_BIT 1
`define FIQ_TO_MONITOR_BIT 2
`define ABORT_TO_MONITOR_BIT 3
`define FIQ_MASK_WRITABLE_BIT 4
`define ABORT_MASK_WRITABLE_BIT 5
`define SECURE_CONFIG_RESET 6'h00

`endif

// ### verilog/coproc_pkg.sv
// holds the types shared by the coprocessor access and secure config block.
// assumes nothing of its surroundings.
package coproc_pkg;

	// two-bit rights encoding, in field order: 00, 01, 10, 11
	typedef enum logic [1:0] {
		RIGHTS_DENIED,
		RIGHTS_KERNEL,
		RIGHTS_RESERVED,
		RIGHTS_FULL
	} rights_t;

	// which register a system coprocessor move selects
	typedef enum logic [1:0] {
		TARGET_NONE,
		TARGET_ACCESS_CTRL,
		TARGET_SECURE_CONFIG
	} sys_target_t;

endpackage

// ### verilog/rights_check.sv
// holds the decode of one two-bit coprocessor rights field.
// assumes the caller gives the current user-mode level from the same clock.
`timescale 1ns/10ps
module rights_check
(
	input wire logic [1:0] rights,
	input wire logic user_mode,
	output logic allow
);

	// denied and reserved both refuse; kernel-only refuses user mode
	function automatic logic rights_allow(input logic [1:0] r, input logic user);
		coproc_pkg::rights_t code;
		code = coproc_pkg::rights_t'(r);
		unique case (code)
			coproc_pkg::RIGHTS_DENIED: rights_allow = 1'b0;
			coproc_pkg::RIGHTS_KERNEL: rights_allow = !user;
			coproc_pkg::RIGHTS_RESERVED: rights_allow = 1'b0;
			coproc_pkg::RIGHTS_FULL: rights_allow = 1'b1;
		endcase
	endfunction

	// decode of the field
	assign allow = rights_allow(rights, user_mode);
endmodule

// ### verilog/secure_config_bank.sv
// holds the secure_config storage, six implemented bits.
// assumes the caller has already checked the secure kernel-privilege access.
`timescale 1ns/10ps
`include "coproc_defs.svh"
module secure_config_bank
(
	input wire logic clock,
	input wire logic nrst,
	input wire logic ce,
	input wire logic write_en,
	input wire logic [`SECURE_CONFIG_WIDTH-1:0] write_data,
	output logic [`SECURE_CONFIG_WIDTH-1:0] value
);

	typedef struct packed {
		logic [`SECURE_CONFIG_WIDTH-1:0] value;
	} bank_state_t;

	bank_state_t s_q;
	bank_state_t s_d;

	// next value: a permitted write replaces all six bits
	always_comb
	begin
		s_d = s_q;
		if (write_en)
		begin
			s_d.value = write_data;
		end
	end

	// reset leaves secure state and own-mode routing, masks secure-only
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			s_q.value <= `SECURE_CONFIG_RESET;
		end
		else if (ce)
		begin
			s_q <= s_d;
		end
	end

	assign value = s_q.value;
endmodule
